//--- dis_pkg.sv
// shared constants, state codes and the core state record of the integrator sequencer
package dis_pkg;

	// ======================================================================
	// configuration register layout
	localparam int CFG_BITS = 12;
	localparam logic [11:0] CFG_RESET = 12'hF00;
	localparam logic [11:0] CFG_KEEP_MASK = 12'hFC1;
	localparam int CFG_TEST_BIT = 0;
	localparam int CFG_QUARTER_BIT = 6;
	localparam int CFG_SPEED_BIT = 7;
	localparam int CFG_FORMAT_BIT = 8;
	localparam logic [3:0] CFG_CNT_LAST = 4'hB;

	// ======================================================================
	// clock divider and timing counts in internal clock periods
	localparam logic [1:0] DIV_LAST = 2'h3;
	localparam logic [10:0] MEAS_LOW_POWER = 11'h610;
	localparam logic [10:0] MEAS_HIGH_SPEED = 11'h64C;
	localparam logic [10:0] READY_DELAY = 11'h566;

	// ======================================================================
	// result stream
	localparam int NUM_CH = 32;
	localparam int WORD_W = 20;
	localparam logic [4:0] BITS_LONG_LAST = 5'h13;
	localparam logic [4:0] BITS_SHORT_LAST = 5'h0F;
	localparam logic [5:0] CH_LAST = 6'h1F;
	localparam logic [5:0] CH_CHAIN = 6'h20;

	// ======================================================================
	// sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_FLUSH_A = 8'h01,
		ST_PREP_A = 8'h02,
		ST_INT_A = 8'h04,
		ST_INT_B_MEAS_A = 8'h08,
		ST_INT_A_MEAS_B = 8'h10,
		ST_INT_B = 8'h20,
		ST_PREP_B = 8'h40,
		ST_FLUSH_B = 8'h80
	} dis_state_t;

	// ======================================================================
	// complete state of the sequencer core
	typedef struct packed {
		dis_state_t seq;
		logic started;
		logic [1:0] div;
		logic sel_seen;
		logic busy;
		logic [10:0] meas_cnt;
		logic meas_second;
		logic meas_side_b;
		logic rdy_run;
		logic [10:0] rdy_cnt;
		logic ready_n;
		logic sclk_prev;
		logic cfg_sclk_prev;
		logic [11:0] cfg_shift;
		logic [3:0] cfg_cnt;
		logic [11:0] cfg;
		logic streaming;
		logic [19:0] word;
		logic [4:0] bit_idx;
		logic [5:0] word_idx;
		logic sout;
		logic conn_a;
		logic conn_b;
	} dis_core_t;

	localparam dis_core_t CORE_RESET = '{
		seq: ST_FLUSH_B, started: 1'b0, div: 2'h0, sel_seen: 1'b0, busy: 1'b0,
		meas_cnt: 11'h000, meas_second: 1'b0, meas_side_b: 1'b0, rdy_run: 1'b0,
		rdy_cnt: 11'h000, ready_n: 1'b1, sclk_prev: 1'b0, cfg_sclk_prev: 1'b0,
		cfg_shift: 12'h000, cfg_cnt: 4'h0, cfg: CFG_RESET, streaming: 1'b0,
		word: 20'h00000, bit_idx: 5'h00, word_idx: 6'h00, sout: 1'b0,
		conn_a: 1'b0, conn_b: 1'b0
	};

endpackage

//--- dis_result_mem.sv
// result word store with a registered read port
`timescale 1ns/1ps
module dis_result_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 20,
	parameter int AW = 5
) (
	// clock
	input wire logic clk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

//--- dis_sequencer.sv
// integrate/measure sequencer, configuration shifter and result readout
// Operation
// - quarter-divide bit set: internal clock is system clock divided by four, else one.
// - all sequencer timing counts scale by four when dividing.
// - test bit disconnects all current inputs from the integrators.
// - result_ready_n goes low when a result is available; host waits for it.
// - result_ready_n stays low until shift_clock goes high then low.
// - reset clears the device; host holds it at least 1 us, glitch free; the bench holds it 16 clock cycles, 640 ns.
// - ready is generated on the divided internal clock; host should poll it.
// - slow conversion leaves gapless mode and halts integration until caught up.
// - eight states, advanced by levels of select and measure-busy.
// - measure-busy is high during any measure, reset, auto-zero cycle.
// - gapless states 3 to 6; 4 and 5 integrate one side, measure other.
// - select toggling while busy goes to state 1 or 8, then 2 or 7.
// - state 1 measures A then B if from 4; state 8 mirrors.
// - states 1, 2, 7, 8 ground the channel inputs.
// - integrations always alternate between sides A and B.
// - start in state 1 with select high, state 8 with select low.
// - measure cycle lasts 1552 periods low power, 1612 high speed.
// - gapless ready asserts 1382 periods after select toggles.
// - configuration is a 12-bit word, msb first, latched on falling shift edge.
// - result bits leave on each falling edge of shift_clock.
// - format bit picks 20-bit words, else upper 16 bits.
`timescale 1ns/1ps
module dis_sequencer
	import dis_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// conversion control
	input wire logic integrate_select,
	// configuration port
	input wire logic cfg_din,
	input wire logic cfg_shift_clock,
	// results from the converter core
	input wire logic adc_result_valid,
	input wire logic [4:0] adc_result_channel,
	input wire logic [19:0] adc_result_code,
	// serial readout
	input wire logic shift_clock,
	input wire logic chain_din,
	output logic result_ready_n,
	output logic serial_out,
	// front end control and status
	output logic connect_side_a,
	output logic connect_side_b,
	output logic measure_busy,
	output logic measure_side_b,
	output logic [7:0] seq_state,
	output logic [11:0] config_value
);

	// ======================================================================
	// decoding helpers
	function automatic logic side_connected(dis_state_t st, logic side_b, logic test);
		logic integ;
		integ = side_b ? (st == ST_INT_B || st == ST_INT_B_MEAS_A)
			: (st == ST_INT_A || st == ST_INT_A_MEAS_B);
		return integ && !test;
	endfunction

	function automatic logic [10:0] meas_len_last(logic [11:0] cfg);
		return (cfg[CFG_SPEED_BIT] ? MEAS_HIGH_SPEED : MEAS_LOW_POWER) - 11'h001;
	endfunction

	// ======================================================================
	// state and memory
	dis_core_t s_r;
	dis_core_t s_nxt;
	logic [19:0] rd_data;
	logic [4:0] rd_addr;
	logic [5:0] rd_next;

	assign rd_next = s_r.word_idx + 6'h01;
	assign rd_addr = (s_r.streaming && shift_clock) ? rd_next[4:0] : 5'h00;

	dis_result_mem #(.DEPTH(NUM_CH), .WIDTH(WORD_W), .AW(5)) u_mem (
		.clk(clk),
		.wr_en(adc_result_valid),
		.wr_addr(adc_result_channel),
		.wr_data(adc_result_code),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// ======================================================================
	// next state
	always_comb begin
		logic tick;
		logic done;
		logic fire;
		logic sclk_fall;
		logic [4:0] bits_last;
		tick = 1'b0;
		done = 1'b0;
		fire = 1'b0;
		sclk_fall = 1'b0;
		bits_last = BITS_LONG_LAST;
		s_nxt = s_r;

		// internal clock enable
		s_nxt.div = s_r.div + 2'h1;
		tick = !s_r.cfg[CFG_QUARTER_BIT] || (s_r.div == DIV_LAST);

		// configuration shifter
		s_nxt.cfg_sclk_prev = cfg_shift_clock;
		if (s_r.cfg_sclk_prev && !cfg_shift_clock) begin
			s_nxt.cfg_shift = {s_r.cfg_shift[10:0], cfg_din};
			if (s_r.cfg_cnt == CFG_CNT_LAST) begin
				s_nxt.cfg = {s_r.cfg_shift[10:0], cfg_din} & CFG_KEEP_MASK;
				s_nxt.cfg_cnt = 4'h0;
			end else begin
				s_nxt.cfg_cnt = s_r.cfg_cnt + 4'h1;
			end
		end

		if (tick) begin
			s_nxt.sel_seen = integrate_select;
			// measure cycle counter
			if (s_r.busy) begin
				if (s_r.meas_cnt == meas_len_last(s_r.cfg)) begin
					s_nxt.meas_cnt = 11'h000;
					done = 1'b1;
					if (s_r.meas_second) begin
						s_nxt.meas_second = 1'b0;
						s_nxt.meas_side_b = !s_r.meas_side_b;
					end else begin
						s_nxt.busy = 1'b0;
					end
				end else begin
					s_nxt.meas_cnt = s_r.meas_cnt + 11'h001;
				end
			end
			// gapless ready delay
			if (s_r.rdy_run) begin
				if (s_r.rdy_cnt == READY_DELAY - 11'h001) begin
					s_nxt.rdy_run = 1'b0;
					fire = 1'b1;
				end else begin
					s_nxt.rdy_cnt = s_r.rdy_cnt + 11'h001;
				end
			end
			if (done && (s_r.seq == ST_FLUSH_A || s_r.seq == ST_FLUSH_B)) begin
				fire = 1'b1;
			end
			// sequencer, level driven
			if (!s_r.started) begin
				s_nxt.started = 1'b1;
				s_nxt.seq = integrate_select ? ST_FLUSH_A : ST_FLUSH_B;
			end else begin
				unique case (s_r.seq)
					ST_FLUSH_A: begin
						if (!s_r.busy) begin
							s_nxt.seq = ST_PREP_A;
						end
					end
					ST_PREP_A: begin
						if (!integrate_select) begin
							s_nxt.seq = ST_INT_A;
						end
					end
					ST_INT_A: begin
						if (integrate_select) begin
							s_nxt.seq = ST_INT_B_MEAS_A;
							s_nxt.busy = 1'b1;
							s_nxt.meas_cnt = 11'h000;
							s_nxt.meas_side_b = 1'b0;
							s_nxt.rdy_run = 1'b1;
							s_nxt.rdy_cnt = 11'h000;
						end
					end
					ST_INT_B_MEAS_A: begin
						if (!integrate_select) begin
							if (s_r.busy) begin
								s_nxt.seq = ST_FLUSH_A;
								if (s_nxt.busy) begin
									s_nxt.meas_second = 1'b1;
								end else begin
									s_nxt.busy = 1'b1;
									s_nxt.meas_side_b = 1'b1;
								end
							end else begin
								s_nxt.seq = ST_INT_A_MEAS_B;
								s_nxt.busy = 1'b1;
								s_nxt.meas_cnt = 11'h000;
								s_nxt.meas_side_b = 1'b1;
								s_nxt.rdy_run = 1'b1;
								s_nxt.rdy_cnt = 11'h000;
							end
						end
					end
					ST_INT_A_MEAS_B: begin
						if (integrate_select) begin
							if (s_r.busy) begin
								s_nxt.seq = ST_FLUSH_B;
								if (s_nxt.busy) begin
									s_nxt.meas_second = 1'b1;
								end else begin
									s_nxt.busy = 1'b1;
									s_nxt.meas_side_b = 1'b0;
								end
							end else begin
								s_nxt.seq = ST_INT_B_MEAS_A;
								s_nxt.busy = 1'b1;
								s_nxt.meas_cnt = 11'h000;
								s_nxt.meas_side_b = 1'b0;
								s_nxt.rdy_run = 1'b1;
								s_nxt.rdy_cnt = 11'h000;
							end
						end
					end
					ST_INT_B: begin
						if (!integrate_select) begin
							s_nxt.seq = ST_INT_A_MEAS_B;
							s_nxt.busy = 1'b1;
							s_nxt.meas_cnt = 11'h000;
							s_nxt.meas_side_b = 1'b1;
							s_nxt.rdy_run = 1'b1;
							s_nxt.rdy_cnt = 11'h000;
						end
					end
					ST_PREP_B: begin
						if (integrate_select) begin
							s_nxt.seq = ST_INT_B;
						end
					end
					ST_FLUSH_B: begin
						if (!s_r.busy) begin
							s_nxt.seq = ST_PREP_B;
						end
					end
					default: begin
						s_nxt.seq = ST_FLUSH_B;
					end
				endcase
			end
		end

		// readout on falling shift_clock
		s_nxt.sclk_prev = shift_clock;
		sclk_fall = s_r.sclk_prev && !shift_clock;
		bits_last = s_r.cfg[CFG_FORMAT_BIT] ? BITS_LONG_LAST : BITS_SHORT_LAST;
		if (sclk_fall) begin
			s_nxt.ready_n = 1'b1;
			if (s_r.streaming) begin
				if (s_r.word_idx == CH_CHAIN) begin
					s_nxt.sout = chain_din;
				end else if (s_r.bit_idx == bits_last) begin
					s_nxt.bit_idx = 5'h00;
					s_nxt.word_idx = rd_next;
					if (s_r.word_idx == CH_LAST) begin
						s_nxt.sout = chain_din;
					end else begin
						s_nxt.word = rd_data;
						s_nxt.sout = rd_data[19];
					end
				end else begin
					s_nxt.bit_idx = s_r.bit_idx + 5'h01;
					s_nxt.word = {s_r.word[18:0], 1'b0};
					s_nxt.sout = s_r.word[18];
				end
			end
		end
		if (fire) begin
			s_nxt.ready_n = 1'b0;
			s_nxt.streaming = 1'b1;
			s_nxt.word_idx = 6'h00;
			s_nxt.bit_idx = 5'h00;
			s_nxt.word = rd_data;
			s_nxt.sout = rd_data[19];
		end

		// front end switches follow the next state
		s_nxt.conn_a = side_connected(s_nxt.seq, 1'b0, s_nxt.cfg[CFG_TEST_BIT]);
		s_nxt.conn_b = side_connected(s_nxt.seq, 1'b1, s_nxt.cfg[CFG_TEST_BIT]);
	end

	// ======================================================================
	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= CORE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ======================================================================
	// outputs
	assign result_ready_n = s_r.ready_n;
	assign serial_out = s_r.sout;
	assign connect_side_a = s_r.conn_a;
	assign connect_side_b = s_r.conn_b;
	assign measure_busy = s_r.busy;
	assign measure_side_b = s_r.meas_side_b;
	assign seq_state = s_r.seq;
	assign config_value = s_r.cfg;

endmodule

//--- dis_sequencer_monitor.sv
// port checker of the integrator sequencer
`timescale 1ns/1ps
module dis_sequencer_monitor
	import dis_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// readout
	input wire logic shift_clock,
	input wire logic result_ready_n,
	// front end and status
	input wire logic connect_side_a,
	input wire logic connect_side_b,
	input wire logic measure_busy,
	input wire logic [7:0] seq_state,
	input wire logic [11:0] config_value
);
	// ==========================================================
	// busy length helper
	logic [13:0] busy_cnt_r;
	logic [13:0] len;
	logic [13:0] slack;
	logic ncont;
	logic len_ok;
	assign len = {3'h0, config_value[CFG_SPEED_BIT] ? MEAS_HIGH_SPEED : MEAS_LOW_POWER}
		<< (config_value[CFG_QUARTER_BIT] ? 2 : 0);
	assign slack = config_value[CFG_QUARTER_BIT] ? 14'h0008 : 14'h0002;
	assign ncont = |(seq_state & 8'hC3);
	assign len_ok = (busy_cnt_r + slack >= len && busy_cnt_r <= len + slack)
		|| (busy_cnt_r + slack >= 2 * len && busy_cnt_r <= 2 * len + slack);
	always_ff @(posedge clk) begin
		if (rst || !measure_busy) begin
			busy_cnt_r <= 14'h0000;
		end else begin
			busy_cnt_r <= busy_cnt_r + 14'h0001;
		end
	end

	// ==========================================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ONEHOT: assert property ($onehot(seq_state))
		else $error("state not one-hot");
	AST_BUSY_STATE: assert property (measure_busy |-> |(seq_state & 8'h99))
		else $error("busy outside a measuring state");
	AST_GROUND: assert property (ncont && $past(ncont) |-> !connect_side_a && !connect_side_b)
		else $error("inputs connected in a non-gapless state");
	AST_TEST: assert property (config_value[0] && $past(config_value[0])
		|-> !connect_side_a && !connect_side_b)
		else $error("inputs connected in test mode");
	AST_CFG_ZERO: assert property (config_value[5:1] == 5'h00)
		else $error("fixed configuration bits not zero");
	AST_READY_HOLD: assert property (!result_ready_n && !$fell(shift_clock)
		|=> !result_ready_n)
		else $error("ready released without a shift fall");
	AST_READY_RISE: assert property ($rose(result_ready_n) && !$past(rst)
		|-> $past(shift_clock, 2) && !$past(shift_clock))
		else $error("ready released with no shift clock pulse");
	AST_BUSY_LEN: assert property ($fell(measure_busy) && !$past(rst) |-> len_ok)
		else $error("measure cycle length wrong");
	COV_STATE_ONE: cover property (seq_state == 8'h01);
	COV_READY: cover property ($fell(result_ready_n));
	COV_QUARTER: cover property ($fell(measure_busy) && config_value[CFG_QUARTER_BIT]);
endmodule

bind dis_sequencer dis_sequencer_monitor u_monitor (.clk(clk), .rst(rst),
	.shift_clock(shift_clock), .result_ready_n(result_ready_n),
	.connect_side_a(connect_side_a), .connect_side_b(connect_side_b),
	.measure_busy(measure_busy), .seq_state(seq_state), .config_value(config_value));

//--- dis_host_model.sv
// host readout model driving the shift clock
`timescale 1ns/1ps
module dis_host_model (
	// clock and request
	input wire logic clk,
	input wire logic req,
	input wire logic [4:0] nbits,
	// device side
	input wire logic result_ready_n,
	input wire logic serial_out,
	output logic shift_clock,
	// result
	output logic [19:0] word,
	output logic done
);
	initial begin
		shift_clock = 1'b0;
		word = 20'h00000;
		done = 1'b0;
		forever begin
			@(negedge clk);
			if (!req) begin
				done = 1'b0;
			end else if (!done && !result_ready_n) begin
				word = 20'h00000;
				for (int i = 0; i < nbits; i++) begin
					word = {word[18:0], serial_out};
					shift_clock = 1'b1;
					repeat (4) @(negedge clk);
					shift_clock = 1'b0;
					repeat (4) @(negedge clk);
				end
				done = 1'b1;
			end
		end
	end
endmodule

//--- test_dual_integrator_sequencer.sv
// self-checking bench of the integrator sequencer
`timescale 1ns/1ps
module test_dual_integrator_sequencer
	import dis_pkg::*;
();
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic rst, integrate_select, cfg_din, cfg_shift_clock, adc_result_valid;
	logic [4:0] adc_result_channel;
	logic [19:0] adc_result_code;
	logic shift_clock, result_ready_n, serial_out, connect_side_a, connect_side_b;
	logic measure_busy, measure_side_b, req, done;
	logic [7:0] seq_state;
	logic [11:0] config_value;
	logic [4:0] nbits;
	logic [19:0] word;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;

	always #20 clk = ~clk;

	dis_sequencer dut (.clk(clk), .rst(rst), .integrate_select(integrate_select),
		.cfg_din(cfg_din), .cfg_shift_clock(cfg_shift_clock),
		.adc_result_valid(adc_result_valid), .adc_result_channel(adc_result_channel),
		.adc_result_code(adc_result_code), .shift_clock(shift_clock), .chain_din(1'b0),
		.result_ready_n(result_ready_n), .serial_out(serial_out),
		.connect_side_a(connect_side_a), .connect_side_b(connect_side_b),
		.measure_busy(measure_busy), .measure_side_b(measure_side_b),
		.seq_state(seq_state), .config_value(config_value));
	dis_host_model host (.clk(clk), .req(req), .nbits(nbits), .result_ready_n(result_ready_n),
		.serial_out(serial_out), .shift_clock(shift_clock), .word(word), .done(done));

	// ==========================================================
	// shared tasks
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_state(input logic [7:0] s);
		while (seq_state !== s) ticks(1);
		check(20'(seq_state), 20'(s));
	endtask
	task automatic cfg_write(input logic [11:0] v, input logic [11:0] exp);
		for (int i = 11; i >= 0; i--) begin
			cfg_din = v[i];
			cfg_shift_clock = 1'b1;
			ticks(2);
			cfg_shift_clock = 1'b0;
			ticks(2);
		end
		ticks(2);
		check(20'(config_value), 20'(exp));
	endtask
	task automatic host_read(input logic [4:0] nb, input logic [19:0] exp);
		nbits = nb;
		req = 1'b1;
		while (done !== 1'b1) ticks(1);
		check(word, exp);
		req = 1'b0;
		while (done !== 1'b0) ticks(1);
	endtask
	task automatic run_toggle(input logic lvl, input int lo, input int hi, input int mlo,
		input int mhi, input logic [4:0] nb, input logic [19:0] exp);
		int n;
		int c0;
		n = 0;
		c0 = cycles;
		integrate_select = lvl;
		while (result_ready_n !== 1'b0 && n < 8000) begin
			ticks(1);
			n++;
		end
		check(20'(n >= lo && n <= hi), 20'h00001);
		host_read(nb, exp);
		while (measure_busy !== 1'b0) ticks(1);
		check(20'((cycles - c0) >= mlo && (cycles - c0) <= mhi), 20'h00001);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		check(20'(config_value), 20'h00F00);
		check(20'(result_ready_n), 20'h00001);
		check(20'(seq_state), 20'h00080);
		wait_state(8'h40);
	endtask
	task automatic t_config();
		cfg_write(12'h13F, 12'h101);
		cfg_write(12'h100, 12'h100);
		adc_result_code = 20'hA5C3E;
		adc_result_valid = 1'b1;
		ticks(1);
		adc_result_valid = 1'b0;
	endtask
	task automatic t_gapless();
		integrate_select = 1'b1;
		wait_state(8'h20);
		ticks(2);
		check(20'(connect_side_b), 20'h00001);
		run_toggle(1'b0, 1380, 1385, 1550, 1555, 5'h14, 20'hA5C3E);
		check(20'(seq_state), 20'h00010);
		check(20'(measure_side_b), 20'h00001);
		integrate_select = 1'b1;
		wait_state(8'h08);
		ticks(2);
		check(20'(connect_side_b), 20'h00001);
		check(20'(measure_side_b), 20'h00000);
	endtask
	task automatic t_ncont();
		integrate_select = 1'b0;
		wait_state(8'h01);
		wait_state(8'h02);
		wait_state(8'h04);
		ticks(2);
		check(20'(connect_side_a), 20'h00001);
		host_read(5'h14, 20'hA5C3E);
	endtask
	task automatic t_modes();
		cfg_write(12'h001, 12'h001);
		run_toggle(1'b1, 1380, 1385, 1550, 1555, 5'h10, 20'h0A5C3);
		cfg_write(12'h040, 12'h040);
		run_toggle(1'b0, 5524, 5536, 6200, 6220, 5'h10, 20'h0A5C3);
		cfg_write(12'h180, 12'h180);
		run_toggle(1'b1, 1380, 1385, 1610, 1615, 5'h14, 20'hA5C3E);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		integrate_select = 1'b0;
		cfg_din = 1'b0;
		cfg_shift_clock = 1'b0;
		adc_result_valid = 1'b0;
		adc_result_channel = 5'h00;
		adc_result_code = 20'h00000;
		req = 1'b0;
		nbits = 5'h14;
		ticks(16);
		rst = 1'b0;
		ticks(1);
		t_reset();
		t_config();
		t_gapless();
		t_ncont();
		t_modes();
		report_and_stop();
	end
endmodule
